// ==== rtl/mpa_pkg.sv ====
// Package: constants and types for the multiport arbiter and bank select.
// Assumes a single bus clock and active-low asynchronous bus reset.
package mpa_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PORTS_DEF = 4;
    localparam int NUM_BANKS     = 8;
    localparam int NUM_STATIC    = 4;
    localparam int NUM_DYNAMIC   = 4;
    localparam int FIRST_DYNAMIC = 4;
    localparam int TIMEOUT_W_DEF = 10;

    // ------------------------------------------------------------
    // Bus transfer codes and burst codes
    // ------------------------------------------------------------
    localparam logic [1:0] TRANS_IDLE   = 2'h0;
    localparam logic [1:0] TRANS_BUSY   = 2'h1;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    localparam logic [1:0] TRANS_SEQ    = 2'h3;

    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_INCR   = 3'h1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] BEATS_RESET = 8'h00;

    // Beats per fixed-length burst code (WRAP4/INCR4 .. WRAP16/INCR16)
    function automatic logic [7:0] burstBeats(input logic [2:0] hburst);
        case (hburst)
            3'h2, 3'h3: burstBeats = 8'h04;
            3'h4, 3'h5: burstBeats = 8'h08;
            3'h6, 3'h7: burstBeats = 8'h10;
            default:    burstBeats = 8'h01;
        endcase
    endfunction

    typedef enum logic [1:0] {
        MPA_IDLE   = 2'b00,
        MPA_OWNED  = 2'b01,
        MPA_BURST  = 2'b10,
        MPA_LOCKED = 2'b11
    } mpa_state_e;

endpackage

// ==== rtl/mpa_arbiter.sv ====
// Arbiter over several slave ports with timeout promotion and bank select.
// Assumes the system decoder drives global and per-bank selects per port
// and that memory sequencing downstream reports readiness on memReady.
`timescale 1ns/1ps

// Summary of operation
// - Without timeouts or open-row requests, lowest-numbered requesting port wins.
// - Each port has its own programmable timeout value.
// - BUSY stalls the transfer; it completes after BUSY is removed.
// - No grant change while the granted master signals BUSY.
// - Locked sequence keeps the port granted until lock drops.
// - Eight banks: 0 to 3 static, 4 to 7 dynamic.
// - Bank n drives static bit n, or dynamic bit n minus four.
// - Each port has a global select beside its bank selects.
// - Among timed-out ports, lowest number wins.
// - No timeouts: open-row requests preferred, lowest port first.
// - A started fixed-length burst keeps its port granted until done.
// - Timeout counter counts down while waiting; zero means timed out unless the port's timeout value is zero.
module mpa_arbiter #(
    parameter int NP = mpa_pkg::NUM_PORTS_DEF,   // Number of slave ports
    parameter int TW = mpa_pkg::TIMEOUT_W_DEF    // Timeout counter width
) (
    input  wire logic               clk,              // Bus clock
    input  wire logic               rstn,             // Async reset, low
    input  wire logic [NP-1:0]      portGlobalSelect, // Per-port global sel
    input  wire logic [NP*8-1:0]    bankSelectN,      // 8 bank selects/port
    input  wire logic [NP*2-1:0]    portTrans,        // Transfer type/port
    input  wire logic [NP*3-1:0]    portBurst,        // Burst type/port
    input  wire logic [NP-1:0]      portMastLock,     // Lock per port
    input  wire logic [NP-1:0]      portRowOpen,      // Target row is open
    input  wire logic [NP*TW-1:0]   portTimeout,      // Timeout value/port
    input  wire logic               memReady,         // Beat accepted
    output logic [NP-1:0]           portGrant,        // One-hot grant
    output logic                    beatGo,           // Beat issued now
    output logic [3:0]              static_chip_select_out_n,  // Static CS
    output logic [3:0]              dynamic_chip_select_out_n  // Dynamic CS
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        mpa_pkg::mpa_state_e   st;
        logic [NP-1:0]         grant;
        logic [7:0]            beats;
        logic [NP-1:0][TW-1:0] cnt;
        logic [3:0]            stCs;
        logic [3:0]            dyCs;
    } mpa_state_s;

    mpa_state_s stateReg;
    mpa_state_s stateNext;

    logic [NP-1:0] req;
    logic [NP-1:0] timedOut;
    logic [NP-1:0] winner;
    logic [1:0]    gTrans;
    logic [2:0]    gBurst;
    logic          gLock;
    logic [7:0]    gBank;

    // Lowest set bit of a request vector
    function automatic logic [NP-1:0] lowestOne(input logic [NP-1:0] v);
        lowestOne = '0;
        for (int i = NP - 1; i >= 0; i--) begin
            if (v[i]) begin
                lowestOne = '0;
                lowestOne[i] = 1'b1;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Requests and timeouts
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : gPort
            // Request needs the global select and an active transfer
            assign req[g] = portGlobalSelect[g] && portTrans[g*2+1];
            // Zero count times out, unless disabled
            assign timedOut[g] = req[g] && !stateReg.grant[g]
                && (portTimeout[g*TW +: TW] != '0)
                && (stateReg.cnt[g] == '0);
        end
    endgenerate

    // Priority: timed out, then open row, then lowest port
    always_comb begin
        if (timedOut != '0) begin
            winner = lowestOne(timedOut);
        end else if ((req & portRowOpen) != '0) begin
            winner = lowestOne(req & portRowOpen);
        end else begin
            winner = lowestOne(req);
        end
    end

    // Signals of the granted port
    always_comb begin
        gTrans = mpa_pkg::TRANS_IDLE;
        gBurst = mpa_pkg::BURST_SINGLE;
        gLock  = 1'b0;
        gBank  = '0;
        for (int i = 0; i < NP; i++) begin
            if (stateReg.grant[i]) begin
                gTrans = portTrans[i*2 +: 2];
                gBurst = portBurst[i*3 +: 3];
                gLock  = portMastLock[i];
                gBank  = bankSelectN[i*8 +: 8];
            end
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic active;
        logic rearb;
        active = 1'b0;
        rearb  = 1'b0;
        stateNext = stateReg;

        // Timeout counters per port
        for (int i = 0; i < NP; i++) begin
            if (!req[i] || stateReg.grant[i]) begin
                stateNext.cnt[i] = portTimeout[i*TW +: TW];
            end else if (stateReg.cnt[i] != '0) begin
                stateNext.cnt[i] = stateReg.cnt[i] - 1'b1;
            end
        end

        // BUSY stalls: no beat issues, grant stays
        active = (stateReg.grant != '0) && gTrans[1];

        case (stateReg.st)
            mpa_pkg::MPA_IDLE: begin
                rearb = 1'b1;
            end
            mpa_pkg::MPA_OWNED: begin
                if (gLock) begin
                    stateNext.st = mpa_pkg::MPA_LOCKED;
                end else if (active && gTrans == mpa_pkg::TRANS_NONSEQ
                        && gBurst > mpa_pkg::BURST_INCR && memReady) begin
                    stateNext.st    = mpa_pkg::MPA_BURST;
                    stateNext.beats = 8'(mpa_pkg::burstBeats(gBurst) - 8'h01);
                end else if (gTrans != mpa_pkg::TRANS_BUSY) begin
                    rearb = !active || memReady;
                end
            end
            mpa_pkg::MPA_BURST: begin
                // Hold the port until the last beat
                if (active && memReady) begin
                    stateNext.beats = 8'(stateReg.beats - 8'h01);
                    if (stateReg.beats == 8'h01) begin
                        stateNext.st = mpa_pkg::MPA_OWNED;
                    end
                end
                if (gTrans == mpa_pkg::TRANS_IDLE) begin
                    stateNext.st = mpa_pkg::MPA_OWNED;
                end
            end
            mpa_pkg::MPA_LOCKED: begin
                // Defer even higher-priority ports until lock ends
                if (!gLock && gTrans != mpa_pkg::TRANS_BUSY) begin
                    stateNext.st = mpa_pkg::MPA_OWNED;
                end
            end
            default: begin
                stateNext.st = mpa_pkg::MPA_IDLE;
            end
        endcase

        if (rearb) begin
            stateNext.grant = winner;
            stateNext.beats = mpa_pkg::BEATS_RESET;
            stateNext.st = (winner != '0) ? mpa_pkg::MPA_OWNED
                                          : mpa_pkg::MPA_IDLE;
        end

        // Bank decode to chip selects, active low
        stateNext.stCs = 4'hF;
        stateNext.dyCs = 4'hF;
        if (stateNext.grant != '0 && stateNext.grant == stateReg.grant
                && active) begin
            stateNext.stCs = ~gBank[mpa_pkg::NUM_STATIC-1:0];
            stateNext.dyCs = ~gBank[mpa_pkg::FIRST_DYNAMIC +:
                                    mpa_pkg::NUM_DYNAMIC];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stateReg.st    <= mpa_pkg::MPA_IDLE;
            stateReg.grant <= '0;
            stateReg.beats <= mpa_pkg::BEATS_RESET;
            stateReg.cnt   <= '0;
            stateReg.stCs  <= 4'hF;
            stateReg.dyCs  <= 4'hF;
        end else begin
            stateReg <= stateNext;
        end
    end

    assign portGrant = stateReg.grant;
    assign beatGo    = (stateReg.grant != '0) && gTrans[1] && memReady;
    assign static_chip_select_out_n  = stateReg.stCs;
    assign dynamic_chip_select_out_n = stateReg.dyCs;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [NP-1:0] expTimed;
    logic [NP-1:0] expLowest;
    logic          bankMixed;
    logic          mustRearb;

    assign expTimed  = lowestOne(timedOut);
    assign expLowest = lowestOne(req);
    assign bankMixed = (gBank[3:0] != '0) && (gBank[7:4] != '0);
    // Cycles in which a new grant must be chosen
    assign mustRearb = (stateReg.st == mpa_pkg::MPA_IDLE)
        || (stateReg.st == mpa_pkg::MPA_OWNED && !gLock
            && gTrans == mpa_pkg::TRANS_IDLE);

    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence busyHeld;
        (stateReg.grant != '0) && gTrans == mpa_pkg::TRANS_BUSY;
    endsequence

    onehot_grant_a: assert property ($onehot0(portGrant))
        else $error("grant not one-hot");
    busy_hold_a: assert property (busyHeld |=> $stable(portGrant))
        else $error("grant moved in busy");
    busy_stall_a: assert property (busyHeld |-> !beatGo)
        else $error("beat during busy");
    busy_count_a: assert property (
        busyHeld |=> stateReg.beats == $past(stateReg.beats))
        else $error("burst beat counted during busy");
    lock_hold_a: assert property (
        stateReg.st == mpa_pkg::MPA_LOCKED && gLock |=> $stable(portGrant))
        else $error("grant moved during lock");
    burst_hold_a: assert property (
        stateReg.st == mpa_pkg::MPA_BURST && gTrans != mpa_pkg::TRANS_IDLE
        |=> $stable(portGrant)) else $error("grant moved in burst");
    timeout_win_a: assert property (
        mustRearb && timedOut != '0 |=> portGrant == $past(expTimed))
        else $error("timed-out port not chosen");
    lowest_win_a: assert property (
        mustRearb && timedOut == '0 && (req & portRowOpen) == '0
        |=> portGrant == $past(expLowest))
        else $error("lowest port not chosen");
    cs_split_a: assert property (
        (&static_chip_select_out_n) || (&dynamic_chip_select_out_n)
        || $past(bankMixed))
        else $error("static and dynamic selected together");

endmodule

// ==== tb/mpa_master_model.sv ====
// Model of the bus masters and system decoder on the slave ports.
// Assumes the bench calls drive() shortly after a rising clock edge.
`timescale 1ns/1ps
module mpa_master_model #(
    parameter int NP = 4  // Number of slave ports
) (
    output logic [NP-1:0]   portGlobalSelect, // Global select
    output logic [NP*8-1:0] bankSelectN,      // Bank selects
    output logic [NP*2-1:0] portTrans,        // Transfer type
    output logic [NP*3-1:0] portBurst,        // Burst type
    output logic [NP-1:0]   portMastLock      // Lock
);
    initial begin
        portGlobalSelect = '0;
        bankSelectN = '0;
        portTrans = '0;
        portBurst = '0;
        portMastLock = '0;
    end
    // Idle port: bank lines flip so stale selects are never trusted
    task automatic drive(input int p, input logic [1:0] tr,
                         input logic [2:0] bk, input logic [2:0] bu,
                         input logic lk);
        logic [31:0] addr;
        // Region start: bits 28:27 stay low, free for flash commands
        addr = {bk, 29'h0};
        portTrans[p*2+:2] = tr;
        portBurst[p*3+:3] = bu;
        portMastLock[p] = lk;
        portGlobalSelect[p] = (tr != mpa_pkg::TRANS_IDLE);
        if (tr == mpa_pkg::TRANS_IDLE) begin
            bankSelectN[p*8+:8] = ~bankSelectN[p*8+:8];
        end else begin
            bankSelectN[p*8+:8] = 8'h01 << addr[31:29];
        end
    endtask
    // Transfer decoded to another slave: lines move, global select low
    task automatic driveElsewhere(input int p, input logic [1:0] tr,
                                  input logic [2:0] bk);
        portTrans[p*2+:2] = tr;
        portGlobalSelect[p] = 1'b0;
        bankSelectN[p*8+:8] = 8'h01 << bk;
    endtask
endmodule

// ==== tb/mpa_arbiter_test.sv ====
// Self-checking bench for the port arbiter and bank select.
// Assumes the master model drives the four slave ports.
`timescale 1ns/1ps
module mpa_arbiter_test;
    logic        clk, rstn, memReady, beat;
    logic [3:0]  gs, lk, rowOpen, grant, stCs, dyCs;
    logic [31:0] bs;
    logic [7:0]  tr;
    logic [11:0] bu;
    logic [39:0] tmo;
    int          fails, samplesChecked;

    mpa_master_model #(.NP(4)) mpa_master_model_inst (
        .portGlobalSelect(gs), .bankSelectN(bs), .portTrans(tr),
        .portBurst(bu), .portMastLock(lk));
    mpa_arbiter #(.NP(4), .TW(10)) mpa_arbiter_inst (
        .clk(clk), .rstn(rstn), .portGlobalSelect(gs), .bankSelectN(bs),
        .portTrans(tr), .portBurst(bu), .portMastLock(lk),
        .portRowOpen(rowOpen), .portTimeout(tmo), .memReady(memReady),
        .portGrant(grant), .beatGo(beat),
        .static_chip_select_out_n(stCs), .dynamic_chip_select_out_n(dyCs));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic tick();
        @(posedge clk);
        #1;
    endtask
    task automatic cmp(input logic [3:0] got, input logic [3:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic req(input int p, input logic [1:0] t,
                       input logic [2:0] bk, input logic [2:0] b,
                       input logic l);
        mpa_master_model_inst.drive(p, t, bk, b, l);
    endtask
    task automatic waitFor(input logic [3:0] old);
        int n;
        n = 0;
        while (grant === old && n < 60) begin
            tick();
            n++;
        end
        if (grant === old) begin
            fails++;
            final_report();
        end
    endtask
    // Drop a port's request and expect the next grant
    task automatic done(input int p, input logic [3:0] exp);
        req(p, 2'h0, 3'h0, 3'h0, 1'b0);
        waitFor(grant);
        cmp(grant, exp);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Transfer meant for another slave must never win a grant
    task automatic testSelect();
        mpa_master_model_inst.driveElsewhere(2, 2'h2, 3'h1);
        repeat (3) begin
            tick();
            cmp(grant, 4'h0);
        end
        req(2, 2'h0, 3'h0, 3'h0, 1'b0);
        tick();
        cmp(stCs, 4'hF);
        $display("global select test done");
    endtask
    task automatic testBanks();
        logic [7:0] sel;
        for (int b = 0; b < 8; b++) begin
            sel = 8'h01 << b;
            req(0, 2'h2, b[2:0], 3'h0, 1'b0);
            waitFor(4'h0);
            memReady = 1'b1;
            #1 cmp({3'h0, beat}, 4'h1);
            tick();
            memReady = 1'b0;
            cmp(stCs, ~sel[3:0]);
            cmp(dyCs, ~sel[7:4]);
            done(0, 4'h0);
        end
        $display("bank select test done");
    endtask
    task automatic testPriority();
        req(2, 2'h2, 3'h1, 3'h0, 1'b0);
        req(1, 2'h2, 3'h2, 3'h0, 1'b0);
        waitFor(4'h0);
        cmp(grant, 4'h2);
        done(1, 4'h4);
        done(2, 4'h0);
        rowOpen = 4'h8;
        req(1, 2'h2, 3'h4, 3'h0, 1'b0);
        req(3, 2'h2, 3'h5, 3'h0, 1'b0);
        waitFor(4'h0);
        cmp(grant, 4'h8);
        done(3, 4'h2);
        done(1, 4'h0);
        rowOpen = 4'h0;
        $display("priority test done");
    endtask
    task automatic testTimeout();
        tmo = {10'h000, 10'h003, 10'h005, 10'h000};
        req(3, 2'h2, 3'h4, 3'h0, 1'b1);
        waitFor(4'h0);
        cmp(grant, 4'h8);
        for (int p = 0; p < 3; p++) begin
            req(p, 2'h2, 3'h0, 3'h0, 1'b0);
        end
        repeat (12) begin
            tick();
            cmp(grant, 4'h8);
        end
        done(3, 4'h2);
        done(1, 4'h4);
        done(2, 4'h1);
        done(0, 4'h0);
        tmo = '0;
        $display("lock and timeout test done");
    endtask
    task automatic testBurst();
        logic [1:0] seq [5] = '{2'h2, 2'h3, 2'h1, 2'h3, 2'h3};
        req(1, 2'h2, 3'h6, 3'h3, 1'b0);
        waitFor(4'h0);
        req(0, 2'h2, 3'h0, 3'h0, 1'b0);
        memReady = 1'b1;
        for (int i = 0; i < 5; i++) begin
            req(1, seq[i], 3'h6, 3'h3, 1'b0);
            #1 cmp({3'h0, beat}, {3'h0, seq[i] != 2'h1});
            cmp(grant, 4'h2);
            tick();
        end
        memReady = 1'b0;
        done(1, 4'h1);
        done(0, 4'h0);
        $display("burst and busy test done");
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        fails = 0;
        samplesChecked = 0;
        rstn = 1'b0;
        memReady = 1'b0;
        rowOpen = 4'h0;
        tmo = '0;
        repeat (5) tick();
        rstn = 1'b1;
        cmp(grant, 4'h0);
        cmp(stCs, 4'hF);
        cmp(dyCs, 4'hF);
        tick();
        testSelect();
        testBanks();
        testPriority();
        testTimeout();
        testBurst();
        final_report();
    end
endmodule
